// ==== bench/testbench.sv ====
/*
  self-checking bench for twrs_top: posted, non-posted, control and watchdog reads
  around interface clock restarts.
  assumes twrs_pkg and the core files are compiled first; no partner model.
*/
`timescale 1ns/100ps
module testbench
  import twrs_pkg::*;
;
  // ************************************************************
  // signals and design
  // ************************************************************
  logic         clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         iclk_active = 1'b1;
  logic         func_tick = 1'b1;
  logic [31:0]  tcv = 32'h0000_00a0;
  logic [31:0]  cap1 = 32'h0000_00a1;
  logic [31:0]  cap2 = 32'h0000_00a2;
  logic [31:0]  wdv = 32'h0000_00a3;
  logic         ctl_wr = 1'b0;
  logic [7:0]   ctl_wdata = 8'h00;
  logic         rd_req = 1'b0;
  twrs_sel_type rd_sel = TWRS_SEL_COUNT;
  logic         rd_ready, rd_ack, rd_stale, wdog_read_safe;
  logic [31:0]  rd_data;
  int           mismatches = 0;
  int           checks = 0;
  int           cycles = 0;

  always #2.5 clk = ~clk;

  twrs_top #(.DATA_W(32), .INSTANCE(1)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .iclk_active(iclk_active), .func_tick(func_tick),
    .timer_count_value(tcv), .capture_value_first(cap1), .capture_value_second(cap2),
    .watchdog_count_value(wdv), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
    .rd_req(rd_req), .rd_sel(rd_sel), .rd_ready(rd_ready), .rd_ack(rd_ack),
    .rd_data(rd_data), .rd_stale(rd_stale), .wdog_read_safe(wdog_read_safe));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic end_sim;
    $display("counts: mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      $display("mismatch %0t cycle limit reached", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks = checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic set_live(input logic [31:0] b);
    tcv  <= b;
    cap1 <= b + 32'h1;
    cap2 <= b + 32'h2;
    wdv  <= b + 32'h3;
  endtask : set_live

  // stops the interface clock, swaps live values once the stop is seen, restarts it
  task automatic restart(input logic [31:0] b, input logic tick);
    @(posedge clk);
    iclk_active <= 1'b0;
    func_tick   <= tick;
    @(posedge clk);
    set_live(b);
    repeat (2) @(posedge clk);
    iclk_active <= 1'b1;
  endtask : restart

  task automatic rd(input twrs_sel_type s, output logic [31:0] d, output logic st,
                    output int lat);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_sel <= s;
    // hold the request until ready is high at the taking edge
    do begin
      @(negedge clk);
    end while (rd_ready !== 1'b1);
    @(posedge clk);
    rd_req <= 1'b0;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (rd_ack !== 1'b1 && lat < 40);
    d  = rd_data;
    st = rd_stale;
    checks = checks + 1;
    if (rd_ack !== 1'b1) begin
      mismatches = mismatches + 1;
      $display("mismatch %0t read not answered", $time);
    end
  endtask : rd

  task automatic wr_ctl(input logic [7:0] v);
    @(posedge clk);
    ctl_wr    <= 1'b1;
    ctl_wdata <= v;
    @(posedge clk);
    ctl_wr    <= 1'b0;
  endtask : wr_ctl

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_posted;
    logic [31:0] d;
    logic        st;
    int          lat;
    restart(32'h0000_0b00, 1'b1);
    rd(TWRS_SEL_COUNT, d, st, lat);
    chk({st, 31'h0}, 32'h8000_0000, "posted early read not flagged");
    chk(d, 32'h0000_00a0, "posted early read not pre-restart copy");
    chk(lat, 32'h1, "posted read latency");
    repeat (8) @(posedge clk);
    rd(TWRS_SEL_COUNT, d, st, lat);
    chk(d, 32'h0000_0b00, "posted settled read");
    chk({31'h0, st}, 32'h0, "posted settled read flagged");
  endtask : test_posted

  task automatic test_nonposted;
    logic [31:0] d;
    logic        st;
    int          lat;
    wr_ctl(8'h08);
    for (int s = 0; s < 3; s++) begin
      restart(32'h0000_0c00 + 32'h10 * s, 1'b0);
      fork
        rd(twrs_sel_type'(s), d, st, lat);
        begin
          repeat (3) @(posedge clk);
          @(negedge clk);
          chk({31'h0, rd_ready}, 32'h0, "ready high while read waits");
          repeat (3) @(posedge clk);
          func_tick <= 1'b1;
        end
      join
      chk(d, 32'h0000_0c00 + 32'h10 * s + s, "non-posted read value");
      chk({31'h0, st}, 32'h0, "non-posted read flagged");
      chk({31'h0, lat >= 5 && lat < 20}, 32'h1, "non-posted read did not wait");
    end
    rd(TWRS_SEL_COUNT, d, st, lat);
    chk(d, 32'h0000_0c20, "settled non-posted read value");
    chk(lat, 32'h1, "settled non-posted read latency");
  endtask : test_nonposted

  task automatic test_ctrl;
    logic [31:0] d;
    logic        st;
    int          lat;
    rd(TWRS_SEL_CTRL, d, st, lat);
    chk(d, 32'h0000_0000, "read-mode bit visible");
    wr_ctl(8'h0c);
    rd(TWRS_SEL_CTRL, d, st, lat);
    chk(d, 32'h0000_0004, "control readback");
    wr_ctl(8'hff);
    rd(TWRS_SEL_CTRL, d, st, lat);
    chk(d, 32'h0000_0004, "unimplemented control bits");
    wr_ctl(8'h08);
  endtask : test_ctrl

  task automatic test_wdog;
    logic [31:0] d;
    logic        st;
    int          k;
    int          lat;
    restart(32'h0000_0d00, 1'b1);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (wdog_read_safe !== 1'b1 && k < 20);
    chk({31'h0, k >= 3 && k <= 6}, 32'h1, "watchdog safe timing");
    restart(32'h0000_0e00, 1'b1);
    rd(TWRS_SEL_WDOG, d, st, lat);
    chk(lat, 32'h1, "watchdog read not posted");
    chk({31'h0, st}, 32'h1, "watchdog early read not flagged");
    chk(d, 32'h0000_0d03, "watchdog early read value");
    repeat (8) @(posedge clk);
    rd(TWRS_SEL_WDOG, d, st, lat);
    chk(d, 32'h0000_0e03, "watchdog settled read");
  endtask : test_wdog

  initial begin
    logic [31:0] d;
    logic        st;
    int          lat;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({30'h0, rd_ready, wdog_read_safe}, 32'h2, "reset outputs");
    @(posedge clk);
    sys_rst <= 1'b0;
    rd(TWRS_SEL_CTRL, d, st, lat);
    chk(d, 32'h0000_0004, "control reset value");
    repeat (8) @(posedge clk);
    test_posted();
    test_nonposted();
    test_ctrl();
    test_wdog();
    end_sim();
  end
endmodule : testbench

// ==== core/twrs_pkg.sv ====
/*
  constants, types and helpers for the timer wakeup read synchronisation block.
  assumes nothing of its surroundings.
*/
package twrs_pkg;

  // ************************************************************
  // interface control register layout
  // ************************************************************
  localparam int           TWRS_CTRL_W        = 8;
  localparam int           TWRS_POSTED_BIT    = 2;
  localparam int           TWRS_READ_MODE_BIT = 3;
  localparam logic [7:0]   TWRS_CTRL_RESET    = 8'h04;
  localparam logic [7:0]   TWRS_CTRL_IMPL     = 8'h0c;

  // ************************************************************
  // resynchronisation after the interface clock restarts
  // ************************************************************
  localparam int           TWRS_RESYNC_ICLK   = 2;
  localparam int           TWRS_RESYNC_FCLK   = 1;
  localparam int           TWRS_CNT_W         = 2;

  // ************************************************************
  // read selectors and states
  // ************************************************************
  typedef enum logic [2:0] {
    TWRS_SEL_COUNT = 3'h0,
    TWRS_SEL_CAP1  = 3'h1,
    TWRS_SEL_CAP2  = 3'h2,
    TWRS_SEL_CTRL  = 3'h3,
    TWRS_SEL_WDOG  = 3'h4
  } twrs_sel_type;

  typedef enum logic [1:0] {
    TWRS_ST_IDLE = 2'b01,
    TWRS_ST_WAIT = 2'b10
  } twrs_state_type;

  // instances whose read-mode bit is write-only
  function automatic logic twrs_is_wo_inst(input int inst);
    return (inst == 1) || (inst == 2) || (inst == 10);
  endfunction : twrs_is_wo_inst

endpackage : twrs_pkg

// ==== core/twrs_resync.sv ====
/*
  resynchroniser: after the interface clock restarts, waits the interface
  cycles and the functional clock cycle before the live values are trusted.
  assumes clk is the interface clock and tick marks functional clock edges.
*/
`timescale 1ns/100ps
module twrs_resync
  import twrs_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // link to the read path
  twrs_sync_if.resync sync
);

  logic [TWRS_CNT_W-1:0] iclk_cnt;

  // ************************************************************
  // settle sequence
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      iclk_cnt     <= '0;
      sync.settled <= 1'b0;
    end else if (!sync.active) begin
      iclk_cnt     <= '0;
      sync.settled <= 1'b0;
    end else if (!sync.settled) begin
      if (iclk_cnt < TWRS_CNT_W'(TWRS_RESYNC_ICLK)) begin
        iclk_cnt <= TWRS_CNT_W'(iclk_cnt + TWRS_CNT_W'(1));
      end else if (sync.tick) begin
        sync.settled <= 1'b1;
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_settle_hold: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(sync.active) |-> !sync.settled [*3])
    else $error("settled before interface cycles elapsed");

  a_settle_tick: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(sync.settled) |-> $past(sync.tick) && $past(sync.active))
    else $error("settled without functional clock cycle");

  a_stop_clears: assert property (@(posedge clk) disable iff (sys_rst)
    !sync.active |=> !sync.settled)
    else $error("settled while interface clock stopped");

  c_settle_done: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(sync.settled));

endmodule : twrs_resync

// ==== core/twrs_sync_if.sv ====
/*
  carrier between the read path and the resynchroniser.
  assumes one clock; tick and active are synchronous to it.
*/
`timescale 1ns/100ps
interface twrs_sync_if;
  logic active;
  logic tick;
  logic settled;

  modport top    (output active, output tick, input settled);
  modport resync (input active, input tick, output settled);
endinterface : twrs_sync_if

// ==== core/twrs_top.sv ====
/*
  timer wakeup read synchronisation: read path of a general purpose timer
  and a watchdog after the interface clock restarts.
  assumes clk is the interface clock; func_tick marks functional clock
  cycles; iclk_active is high while the interface clock runs; all inputs
  are synchronous to clk.
*/
// Summary of operation
// - In posted mode, timer count and capture reads right after clock restart give stale values.
// - In non-posted mode those reads wait for resynchronisation and return live values.
// - A watchdog count read right after clock restart may give a stale value.
// - The watchdog is always posted and no control bit can change that.
// - On timer instances 1, 2 and 10 the read-mode bit is write-only and reads back as zero.
`timescale 1ns/100ps
module twrs_top
  import twrs_pkg::*;
#(
  parameter int DATA_W   = 32,
  parameter int INSTANCE = 1
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // clock state
  input  wire logic              iclk_active,
  input  wire logic              func_tick,
  // live values from the functional side
  input  wire logic [DATA_W-1:0] timer_count_value,
  input  wire logic [DATA_W-1:0] capture_value_first,
  input  wire logic [DATA_W-1:0] capture_value_second,
  input  wire logic [DATA_W-1:0] watchdog_count_value,
  // control write
  input  wire logic              ctl_wr,
  input  wire logic [7:0]        ctl_wdata,
  // read request and answer
  input  wire logic              rd_req,
  input  wire twrs_sel_type      rd_sel,
  output logic                   rd_ready,
  output logic                   rd_ack,
  output logic [DATA_W-1:0]      rd_data,
  output logic                   rd_stale,
  // status
  output logic                   wdog_read_safe
);

  twrs_sync_if    sync ();
  twrs_state_type state;
  logic [7:0]     sync_interface_control;
  logic [DATA_W-1:0] shadow_count;
  logic [DATA_W-1:0] shadow_cap1;
  logic [DATA_W-1:0] shadow_cap2;
  logic [DATA_W-1:0] shadow_wdog;
  twrs_sel_type   pend_sel;
  logic           non_posted;
  logic           take;
  logic [7:0]     ctrl_view;

  assign sync.active = iclk_active;
  assign sync.tick   = func_tick;

  twrs_resync u_resync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sync    (sync)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [DATA_W-1:0] live_of(input twrs_sel_type s);
    case (s)
      TWRS_SEL_CAP1: live_of = capture_value_first;
      TWRS_SEL_CAP2: live_of = capture_value_second;
      default:       live_of = timer_count_value;
    endcase
  endfunction : live_of

  function automatic logic is_timer_sel(input twrs_sel_type s);
    return (s == TWRS_SEL_COUNT) || (s == TWRS_SEL_CAP1) || (s == TWRS_SEL_CAP2);
  endfunction : is_timer_sel

  // ************************************************************
  // control register
  // ************************************************************
  assign non_posted = !sync_interface_control[TWRS_POSTED_BIT]
                      && sync_interface_control[TWRS_READ_MODE_BIT];

  always_comb begin
    ctrl_view = sync_interface_control;
    if (twrs_is_wo_inst(INSTANCE)) begin
      ctrl_view[TWRS_READ_MODE_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_interface_control <= TWRS_CTRL_RESET;
    end else if (ctl_wr) begin
      sync_interface_control <= ctl_wdata & TWRS_CTRL_IMPL;
    end
  end

  // ************************************************************
  // shadow copies seen by posted reads
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shadow_count <= '0;
      shadow_cap1  <= '0;
      shadow_cap2  <= '0;
      shadow_wdog  <= '0;
    end else if (sync.settled) begin
      shadow_count <= timer_count_value;
      shadow_cap1  <= capture_value_first;
      shadow_cap2  <= capture_value_second;
      shadow_wdog  <= watchdog_count_value;
    end
  end

  // ************************************************************
  // read state machine
  // ************************************************************
  assign rd_ready       = (state == TWRS_ST_IDLE);
  assign take           = rd_req && rd_ready;
  assign wdog_read_safe = sync.settled;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= TWRS_ST_IDLE;
      pend_sel <= TWRS_SEL_COUNT;
      rd_ack   <= 1'b0;
      rd_data  <= '0;
      rd_stale <= 1'b0;
    end else begin
      rd_ack   <= 1'b0;
      case (state)
        TWRS_ST_IDLE: begin
          if (take) begin
            pend_sel <= rd_sel;
            if (is_timer_sel(rd_sel) && non_posted) begin
              if (sync.settled) begin
                rd_ack   <= 1'b1;
                rd_data  <= live_of(rd_sel);
                rd_stale <= 1'b0;
              end else begin
                state <= TWRS_ST_WAIT;
              end
            end else begin
              rd_ack   <= 1'b1;
              rd_stale <= !sync.settled && (rd_sel != TWRS_SEL_CTRL);
              case (rd_sel)
                TWRS_SEL_CAP1: rd_data <= shadow_cap1;
                TWRS_SEL_CAP2: rd_data <= shadow_cap2;
                TWRS_SEL_CTRL: rd_data <= DATA_W'(ctrl_view);
                TWRS_SEL_WDOG: rd_data <= shadow_wdog;
                default:       rd_data <= shadow_count;
              endcase
            end
          end
        end
        TWRS_ST_WAIT: begin
          if (sync.settled) begin
            rd_ack   <= 1'b1;
            rd_data  <= live_of(pend_sel);
            rd_stale <= 1'b0;
            state    <= TWRS_ST_IDLE;
          end
        end
        default: state <= TWRS_ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_wait_no_ack: assert property (@(posedge clk) disable iff (sys_rst)
    (state == TWRS_ST_WAIT) && !sync.settled |=> !rd_ack)
    else $error("non-posted read answered before settle");

  a_wait_release: assert property (@(posedge clk) disable iff (sys_rst)
    (state == TWRS_ST_WAIT) && sync.settled |=> rd_ack && !rd_stale
      && rd_data == $past(live_of(pend_sel)))
    else $error("non-posted read not answered with live value");

  a_np_settled_live: assert property (@(posedge clk) disable iff (sys_rst)
    take && non_posted && is_timer_sel(rd_sel) && sync.settled
      |=> rd_ack && rd_data == $past(live_of(rd_sel)))
    else $error("settled non-posted read not live");

  a_posted_fast: assert property (@(posedge clk) disable iff (sys_rst)
    take && !(non_posted && is_timer_sel(rd_sel)) |=> rd_ack)
    else $error("posted read not answered next cycle");

  a_posted_stale: assert property (@(posedge clk) disable iff (sys_rst)
    take && !non_posted && rd_sel == TWRS_SEL_COUNT && !sync.settled
      |=> rd_stale && rd_data == $past(shadow_count))
    else $error("posted read after restart not flagged stale");

  a_wdog_posted: assert property (@(posedge clk) disable iff (sys_rst)
    take && rd_sel == TWRS_SEL_WDOG |=> rd_ack && rd_data == $past(shadow_wdog))
    else $error("watchdog read not served from posted copy");

  a_ctrl_wo_mask: assert property (@(posedge clk) disable iff (sys_rst)
    take && rd_sel == TWRS_SEL_CTRL && twrs_is_wo_inst(INSTANCE)
      |=> rd_data[TWRS_READ_MODE_BIT] == 1'b0)
    else $error("write-only read-mode bit visible");

  a_wdog_safe: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(iclk_active) |-> !wdog_read_safe [*3])
    else $error("watchdog reported safe too early");

  c_np_wait: cover property (@(posedge clk) disable iff (sys_rst)
    (state == TWRS_ST_WAIT) ##[1:20] rd_ack);

  c_wdog_stale: cover property (@(posedge clk) disable iff (sys_rst)
    take && rd_sel == TWRS_SEL_WDOG && !sync.settled);

  c_ctrl_read: cover property (@(posedge clk) disable iff (sys_rst)
    take && rd_sel == TWRS_SEL_CTRL);

endmodule : twrs_top
